// [src/csfu_status_flags.sv]
// processor status flag unit with branch test and interrupt/break push
//
// Overview of operation
// - eight-bit word: five result, three mode flags
// - branches test carry, zero, overflow or negative
// - zero, overflow, negative meaningless after decimal ops
// - carry from alu arithmetic, shifts and rotates
// - zero set on zero result, else cleared
// - mask blocks interrupts but never software break
// - decimal flag picks binary or corrected decimal
// - decimal applies only to add and subtract
// - live break bit zero, pushed copy one for software break, zero for interrupt
// - memory-mode flag selects memory-to-memory operation
// - overflow set on signed result out of range
// - bit test copies memory bits six, seven
// - negative set on negative result, else cleared
// - only listed flags have set or clear operations
// - accepted interrupt pushes pc, status, then masks
`timescale 1ns/1ps
module csfu_status_flags (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // operation from the sequencer
  input  wire logic                        opValid,
  input  wire csfu_pkg::csfu_op_type       opIn,
  input  wire logic [15:0]                 pcIn,
  // branch test request
  input  wire logic                        branchValid,
  input  wire csfu_pkg::csfu_branch_type   branchIn,
  // pending maskable interrupt
  input  wire logic                        irqRequest,
  // status word and results
  output logic      [7:0]                  statusFlags_r,
  output logic      [7:0]                  aluResult_r,
  output logic                             resultValid_r,
  output logic                             zvnValid_r,
  output logic                             memModeActive_r,
  // branch answer
  output logic                             branchDone_r,
  output logic                             branchTaken_r,
  // stack push and vectoring
  output logic                             pushValid_r,
  output logic      [7:0]                  pushData_r,
  output logic                             irqAck_r,
  output logic                             vectorLoad_r,
  output logic                             vectorIsBreak_r,
  output logic                             busy_r
);
  // push sequencer state and saved context
  csfu_pkg::csfu_state_type state_r, state_nxt;
  logic             isBreak_r;            // current push caused by break
  logic [15:0]      pcSave_r;             // pc held during the push
  logic [7:0]       flags_nxt;            // next status word

  // operation decode
  wire logic stIdle   = state_r == csfu_pkg::ST_IDLE;
  wire logic opTake   = opValid && stIdle;   // ops ignored while pushing
  wire csfu_pkg::csfu_opcode_type code = opIn.code;
  wire logic isAdd    = code == csfu_pkg::OP_ADD;
  wire logic isSub    = code == csfu_pkg::OP_SUB;
  wire logic isCmp    = code == csfu_pkg::OP_CMP;
  wire logic isBreak  = code == csfu_pkg::OP_BREAK;
  wire logic isArith  = isAdd || isSub;

  // break is never masked; maskable request waits for a free cycle
  wire logic brkStart = opTake && isBreak;
  wire logic irqStart = stIdle && !opValid && irqRequest
                        && !statusFlags_r[csfu_pkg::FLAG_I];

  // adder: decimal only for add and subtract, compare stays binary
  wire logic       decActive = statusFlags_r[csfu_pkg::FLAG_D] && isArith;
  wire logic       addCin    = isCmp ? 1'b1 : statusFlags_r[csfu_pkg::FLAG_C];
  logic      [7:0] addSum;
  logic            addCout;
  logic            addOvf;

  csfu_dec_adder u_adder (
    .a        (opIn.accVal),
    .b        (opIn.memVal),
    .carryIn  (addCin),
    .subtract (isSub || isCmp),
    .decimal  (decActive),
    .sum      (addSum),
    .carryOut (addCout),
    .overflow (addOvf)
  );

  // shift and rotate on the memory operand
  wire logic       oldC     = statusFlags_r[csfu_pkg::FLAG_C];
  wire logic [7:0] shVal    = opIn.memVal;
  wire logic       isLeft   = (code == csfu_pkg::OP_ASL) || (code == csfu_pkg::OP_ROL);
  wire logic       isShift  = isLeft || (code == csfu_pkg::OP_LSR)
                              || (code == csfu_pkg::OP_ROR);
  wire logic       shInBit  = ((code == csfu_pkg::OP_ROL) || (code == csfu_pkg::OP_ROR))
                              ? oldC : 1'b0;
  wire logic [7:0] shRes    = isLeft ? {shVal[6:0], shInBit} : {shInBit, shVal[7:1]};
  wire logic       shOut    = isLeft ? shVal[7] : shVal[0];

  // result byte that drives zero and negative
  wire logic [7:0] resByte  = (isArith || isCmp) ? addSum :
                              isShift ? shRes : opIn.memVal;
  wire logic       resZero  = resByte == 8'h00;
  wire logic       bitZero  = (opIn.accVal & opIn.memVal) == 8'h00;

  // flag update; every flag starts from its old value
  always_comb begin
    flags_nxt = statusFlags_r;
    if (opTake) begin
      case (code)
        csfu_pkg::OP_ADD, csfu_pkg::OP_SUB: begin
          flags_nxt[csfu_pkg::FLAG_C] = addCout;
          flags_nxt[csfu_pkg::FLAG_Z] = resZero;
          flags_nxt[csfu_pkg::FLAG_V] = addOvf;
          flags_nxt[csfu_pkg::FLAG_N] = resByte[7];
        end
        csfu_pkg::OP_CMP: begin
          flags_nxt[csfu_pkg::FLAG_C] = addCout;
          flags_nxt[csfu_pkg::FLAG_Z] = resZero;
          flags_nxt[csfu_pkg::FLAG_N] = resByte[7];
        end
        csfu_pkg::OP_ASL, csfu_pkg::OP_LSR,
        csfu_pkg::OP_ROL, csfu_pkg::OP_ROR: begin
          flags_nxt[csfu_pkg::FLAG_C] = shOut;
          flags_nxt[csfu_pkg::FLAG_Z] = resZero;
          flags_nxt[csfu_pkg::FLAG_N] = resByte[7];
        end
        csfu_pkg::OP_XFER: begin
          flags_nxt[csfu_pkg::FLAG_Z] = resZero;
          flags_nxt[csfu_pkg::FLAG_N] = resByte[7];
        end
        csfu_pkg::OP_BITTEST: begin
          flags_nxt[csfu_pkg::FLAG_Z] = bitZero;
          flags_nxt[csfu_pkg::FLAG_V] = opIn.memVal[csfu_pkg::TEST_BIT_V];
          flags_nxt[csfu_pkg::FLAG_N] = opIn.memVal[csfu_pkg::TEST_BIT_N];
        end
        // dedicated set and clear operations; no way to set V, Z, N, B
        csfu_pkg::OP_SETC: flags_nxt[csfu_pkg::FLAG_C] = 1'b1;
        csfu_pkg::OP_CLRC: flags_nxt[csfu_pkg::FLAG_C] = 1'b0;
        csfu_pkg::OP_SETI: flags_nxt[csfu_pkg::FLAG_I] = 1'b1;
        csfu_pkg::OP_CLRI: flags_nxt[csfu_pkg::FLAG_I] = 1'b0;
        csfu_pkg::OP_SETD: flags_nxt[csfu_pkg::FLAG_D] = 1'b1;
        csfu_pkg::OP_CLRD: flags_nxt[csfu_pkg::FLAG_D] = 1'b0;
        csfu_pkg::OP_SETT: flags_nxt[csfu_pkg::FLAG_T] = 1'b1;
        csfu_pkg::OP_CLRT: flags_nxt[csfu_pkg::FLAG_T] = 1'b0;
        csfu_pkg::OP_CLRV: flags_nxt[csfu_pkg::FLAG_V] = 1'b0;
        // pulled word: whole byte, break bit dropped below
        csfu_pkg::OP_LOADPS: flags_nxt = opIn.memVal;
        default: flags_nxt = statusFlags_r;
      endcase
    end
    // mask set as the status byte goes out during a push
    if (state_r == csfu_pkg::ST_PUSHPS) begin
      flags_nxt[csfu_pkg::FLAG_I] = 1'b1;
    end
    // live break bit never holds a one
    flags_nxt[csfu_pkg::FLAG_B] = 1'b0;
  end

  // push sequencer: high pc, low pc, status, then vector
  always_comb begin
    case (state_r)
      csfu_pkg::ST_IDLE:   state_nxt = (brkStart || irqStart) ? csfu_pkg::ST_PUSHHI
                                                              : csfu_pkg::ST_IDLE;
      csfu_pkg::ST_PUSHHI: state_nxt = csfu_pkg::ST_PUSHLO;
      csfu_pkg::ST_PUSHLO: state_nxt = csfu_pkg::ST_PUSHPS;
      csfu_pkg::ST_PUSHPS: state_nxt = csfu_pkg::ST_IDLE;
      default:             state_nxt = csfu_pkg::ST_IDLE;
    endcase
  end

  // pushed status copy carries break bit only for a software break
  wire logic [7:0] pushPs = {statusFlags_r[7:5], isBreak_r, statusFlags_r[3:0]};
  wire logic [7:0] pushByte = (state_r == csfu_pkg::ST_PUSHHI) ? pcSave_r[15:8] :
                              (state_r == csfu_pkg::ST_PUSHLO) ? pcSave_r[7:0] : pushPs;
  wire logic       pushing  = !stIdle;

  // branch condition on one of the four result flags
  wire logic brFlag = (branchIn.flagSel == csfu_pkg::BR_SEL_C) ? statusFlags_r[csfu_pkg::FLAG_C] :
                      (branchIn.flagSel == csfu_pkg::BR_SEL_Z) ? statusFlags_r[csfu_pkg::FLAG_Z] :
                      (branchIn.flagSel == csfu_pkg::BR_SEL_V) ? statusFlags_r[csfu_pkg::FLAG_V] :
                                                                 statusFlags_r[csfu_pkg::FLAG_N];

  // status word and sequencer state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      statusFlags_r <= csfu_pkg::PS_RESET;
      state_r       <= csfu_pkg::ST_IDLE;
    end else begin
      statusFlags_r <= flags_nxt;
      state_r       <= state_nxt;
    end
  end

  // context captured when a push starts
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      isBreak_r <= 1'b0;
      pcSave_r  <= 16'h0000;
    end else if (stIdle && (brkStart || irqStart)) begin
      isBreak_r <= brkStart;
      pcSave_r  <= pcIn;
    end
  end

  // arithmetic result and validity of zero, overflow, negative
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aluResult_r   <= 8'h00;
      resultValid_r <= 1'b0;
      zvnValid_r    <= 1'b1;
    end else begin
      resultValid_r <= opTake && (isArith || isCmp || isShift);
      if (opTake) begin
        aluResult_r <= resByte;
      end
      // decimal results leave zero, overflow, negative unreliable
      if (opTake && isArith) begin
        zvnValid_r <= !decActive;
      end else if (opTake && (isCmp || isShift || code == csfu_pkg::OP_XFER
                              || code == csfu_pkg::OP_BITTEST
                              || code == csfu_pkg::OP_LOADPS)) begin
        zvnValid_r <= 1'b1;
      end
    end
  end

  // branch answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      branchDone_r  <= 1'b0;
      branchTaken_r <= 1'b0;
    end else begin
      branchDone_r  <= branchValid;
      branchTaken_r <= branchValid && (brFlag == branchIn.wantSet);
    end
  end

  // stack push bytes, request clear and vector strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pushValid_r     <= 1'b0;
      pushData_r      <= 8'h00;
      irqAck_r        <= 1'b0;
      vectorLoad_r    <= 1'b0;
      vectorIsBreak_r <= 1'b0;
      busy_r          <= 1'b0;
      memModeActive_r <= 1'b0;
    end else begin
      pushValid_r     <= pushing;
      pushData_r      <= pushing ? pushByte : 8'h00;
      irqAck_r        <= (state_r == csfu_pkg::ST_PUSHPS) && !isBreak_r;
      vectorLoad_r    <= state_r == csfu_pkg::ST_PUSHPS;
      vectorIsBreak_r <= (state_r == csfu_pkg::ST_PUSHPS) && isBreak_r;
      busy_r          <= state_nxt != csfu_pkg::ST_IDLE;
      memModeActive_r <= flags_nxt[csfu_pkg::FLAG_T];
    end
  end

  // checks
  live_break_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !statusFlags_r[csfu_pkg::FLAG_B]) else $error("live break bit set");
  break_push_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (opValid && stIdle && opIn.code == csfu_pkg::OP_BREAK) |-> ##4 (pushValid_r && pushData_r[4]))
    else $error("break push copy lacks break bit");
  irq_mask_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (stIdle && statusFlags_r[csfu_pkg::FLAG_I] && !opValid) |=> state_r == csfu_pkg::ST_IDLE)
    else $error("masked interrupt accepted");
  irq_push_seq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (stIdle && !opValid && irqRequest && !statusFlags_r[csfu_pkg::FLAG_I])
    |=> ##1 pushValid_r[*3] ##0 irqAck_r ##1 statusFlags_r[csfu_pkg::FLAG_I])
    else $error("interrupt push sequence wrong");
  carry_from_add_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (opValid && stIdle && opIn.code == csfu_pkg::OP_ADD && !statusFlags_r[csfu_pkg::FLAG_D])
    |=> statusFlags_r[csfu_pkg::FLAG_C] ==
        $past({1'b0, opIn.accVal} + {1'b0, opIn.memVal} + {8'h00, addCin}) >> 8)
    else $error("carry not from binary add");
  zero_on_xfer_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (opValid && stIdle && opIn.code == csfu_pkg::OP_XFER)
    |=> statusFlags_r[csfu_pkg::FLAG_Z] == ($past(opIn.memVal) == 8'h00)
        && statusFlags_r[csfu_pkg::FLAG_N] == $past(opIn.memVal[7]))
    else $error("zero or negative wrong after transfer");
  bit_test_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (opValid && stIdle && opIn.code == csfu_pkg::OP_BITTEST)
    |=> statusFlags_r[7:6] == $past(opIn.memVal[7:6]))
    else $error("bit test copy wrong");
  overflow_add_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (opValid && stIdle && opIn.code == csfu_pkg::OP_ADD && !opIn.accVal[7] && !opIn.memVal[7]
     && !statusFlags_r[csfu_pkg::FLAG_D] && (opIn.accVal + opIn.memVal) > 8'h7f)
    |=> statusFlags_r[csfu_pkg::FLAG_V]) else $error("signed overflow missed");
  idle_flags_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (stIdle && !opValid && !irqStart) |=> $stable(statusFlags_r))
    else $error("flags changed without cause");
  branch_answer_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    branchValid && branchIn.flagSel == csfu_pkg::BR_SEL_Z
    |=> branchDone_r && branchTaken_r == ($past(statusFlags_r[1]) == $past(branchIn.wantSet)))
    else $error("branch answer wrong");
  decimal_valid_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (opValid && stIdle && opIn.code == csfu_pkg::OP_SUB && statusFlags_r[csfu_pkg::FLAG_D])
    |=> !zvnValid_r) else $error("decimal result marked valid");

  cov_break_push: cover property (@(posedge ref_clk) disable iff (sys_rst)
    vectorLoad_r && vectorIsBreak_r);
  cov_irq_push: cover property (@(posedge ref_clk) disable iff (sys_rst) irqAck_r);
  cov_decimal_add: cover property (@(posedge ref_clk) disable iff (sys_rst)
    opTake && isAdd && decActive && addCout);
  cov_branch_taken: cover property (@(posedge ref_clk) disable iff (sys_rst) branchTaken_r);
endmodule

// [src/csfu_pkg.sv]
// shared constants and types for the cpu status flag unit
package csfu_pkg;

  // bit positions inside the status word
  localparam int FLAG_C = 0;             // carry
  localparam int FLAG_Z = 1;             // zero
  localparam int FLAG_I = 2;             // interrupt mask
  localparam int FLAG_D = 3;             // decimal mode
  localparam int FLAG_B = 4;             // break, live copy always zero
  localparam int FLAG_T = 5;             // memory-to-memory mode
  localparam int FLAG_V = 6;             // overflow
  localparam int FLAG_N = 7;             // negative

  // status word after reset: interrupts masked, everything else clear
  localparam logic [7:0] PS_RESET = 8'h04;

  // number of result flags and mode flags
  localparam int RESULT_FLAG_COUNT = 5;
  localparam int MODE_FLAG_COUNT   = 3;

  // push sequence length in cycles (high pc, low pc, status)
  localparam int PUSH_CYCLES = 3;

  // memory bit-test source bits
  localparam int TEST_BIT_V = 6;
  localparam int TEST_BIT_N = 7;

  // branch flag selector codes
  localparam logic [1:0] BR_SEL_C = 2'h0;
  localparam logic [1:0] BR_SEL_Z = 2'h1;
  localparam logic [1:0] BR_SEL_V = 2'h2;
  localparam logic [1:0] BR_SEL_N = 2'h3;

  // operations issued by the sequencer
  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_ADD      = 5'h01,   // add with carry
    OP_SUB      = 5'h02,   // subtract_with_borrow_op
    OP_CMP      = 5'h03,   // compare, binary only
    OP_XFER     = 5'h04,   // data transfer / logic result on memVal
    OP_ASL      = 5'h05,
    OP_LSR      = 5'h06,
    OP_ROL      = 5'h07,
    OP_ROR      = 5'h08,
    OP_BITTEST  = 5'h09,
    OP_SETC     = 5'h0a,   // set_carry_op
    OP_CLRC     = 5'h0b,   // clear_carry_op
    OP_SETI     = 5'h0c,   // mask_interrupts_op
    OP_CLRI     = 5'h0d,   // unmask_interrupts_op
    OP_SETD     = 5'h0e,   // set_decimal_op
    OP_CLRD     = 5'h0f,   // clear_decimal_op
    OP_SETT     = 5'h10,   // enable memory mode
    OP_CLRT     = 5'h11,   // disable_mem_mode_op
    OP_CLRV     = 5'h12,   // clear_overflow_op
    OP_LOADPS   = 5'h13,   // pull status word from stack
    OP_BREAK    = 5'h14    // software_break_op
  } csfu_opcode_type;

  // one operation from the sequencer
  typedef struct packed {
    csfu_opcode_type code;
    logic [7:0]      accVal;
    logic [7:0]      memVal;
  } csfu_op_type;

  // one branch test request
  typedef struct packed {
    logic [1:0] flagSel;
    logic       wantSet;
  } csfu_branch_type;

  // push sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_PUSHHI = 4'h2,
    ST_PUSHLO = 4'h4,
    ST_PUSHPS = 4'h8
  } csfu_state_type;

endpackage

// [src/csfu_dec_adder.sv]
// binary / decimal byte adder with carry and overflow
`timescale 1ns/1ps
module csfu_dec_adder (
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       carryIn,
  // mode
  input  wire logic       subtract,
  input  wire logic       decimal,
  // result
  output logic      [7:0] sum,
  output logic            carryOut,
  output logic            overflow
);
  // subtraction is addition of the inverted operand
  wire logic [7:0] bEff   = subtract ? ~b : b;
  wire logic [8:0] binSum = {1'b0, a} + {1'b0, bEff} + {8'h00, carryIn};
  wire logic [4:0] loRaw  = {1'b0, a[3:0]} + {1'b0, bEff[3:0]} + {4'h0, carryIn};

  // decimal add: fix each nibble above nine
  wire logic       loAddFix = loRaw > 5'h09;
  wire logic [4:0] loAdd    = loAddFix ? loRaw + 5'h06 : loRaw;
  wire logic [4:0] hiRaw    = {1'b0, a[7:4]} + {1'b0, bEff[7:4]} + {4'h0, loAddFix};
  wire logic       hiAddFix = hiRaw > 5'h09;
  wire logic [4:0] hiAdd    = hiAddFix ? hiRaw + 5'h06 : hiRaw;

  // decimal subtract: take six back from any nibble that borrowed
  wire logic [3:0] loSub = loRaw[4] ? binSum[3:0] : binSum[3:0] - 4'h6;
  wire logic [3:0] hiSub = binSum[8] ? binSum[7:4] : binSum[7:4] - 4'h6;

  // overflow always from the binary sum; only meaningful in binary mode
  assign overflow = (a[7] == bEff[7]) && (binSum[7] != a[7]);
  assign sum      = !decimal ? binSum[7:0] :
                    subtract ? {hiSub, loSub} : {hiAdd[3:0], loAdd[3:0]};
  assign carryOut = (decimal && !subtract) ? hiAddFix : binSum[8];
endmodule

// [tb/csfu_stack_model.sv]
// stack model on the far side: collects bytes pushed by the flag unit
`timescale 1ns/1ps
module csfu_stack_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // push stream from the flag unit
  input  wire logic        pushValid_r,
  input  wire logic [7:0]  pushData_r,
  // last three bytes, oldest in the top byte
  output logic      [23:0] stackWord,
  output logic      [7:0]  pushCnt
);
  // shifting keeps arrival order visible: high pc, low pc, status
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stackWord <= 24'h00_0000;
      pushCnt   <= 8'h00;
    end else if (pushValid_r) begin
      stackWord <= {stackWord[15:0], pushData_r};
      pushCnt   <= pushCnt + 8'h01;
    end
  end
endmodule

// [tb/csfu_status_flags_tb.sv]
// self-checking bench for the status flag unit
`timescale 1ns/1ps
module csfu_status_flags_tb;
  logic                      ref_clk, sys_rst, opValid, branchValid, irqRequest;
  csfu_pkg::csfu_op_type     opIn;
  csfu_pkg::csfu_branch_type branchIn;
  logic [15:0]               pcIn;
  logic [7:0]                statusFlags_r, aluResult_r, pushData_r, pushCnt;
  logic                      resultValid_r, zvnValid_r, memModeActive_r, busy_r;
  logic                      branchDone_r, branchTaken_r, pushValid_r;
  logic                      irqAck_r, vectorLoad_r, vectorIsBreak_r;
  logic [23:0]               stackWord;
  int                        error_cnt, cmp_count, i, k;
  // set and clear operations with the status word each one leaves
  csfu_pkg::csfu_opcode_type sc [8] = '{csfu_pkg::OP_SETC, csfu_pkg::OP_SETD,
                                        csfu_pkg::OP_SETT, csfu_pkg::OP_CLRC,
                                        csfu_pkg::OP_CLRD, csfu_pkg::OP_CLRT,
                                        csfu_pkg::OP_CLRI, csfu_pkg::OP_SETI};
  logic [7:0]      sw [8] = '{8'h05, 8'h0d, 8'h2d, 8'h2c, 8'h24, 8'h04, 8'h00, 8'h04};
  logic [7:0]      bx [4] = '{8'h00, 8'h01, 8'h06, 8'h07};

  csfu_status_flags uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .opValid(opValid),
    .opIn(opIn), .pcIn(pcIn), .branchValid(branchValid), .branchIn(branchIn),
    .irqRequest(irqRequest), .statusFlags_r(statusFlags_r), .aluResult_r(aluResult_r),
    .resultValid_r(resultValid_r), .zvnValid_r(zvnValid_r),
    .memModeActive_r(memModeActive_r), .branchDone_r(branchDone_r),
    .branchTaken_r(branchTaken_r), .pushValid_r(pushValid_r), .pushData_r(pushData_r),
    .irqAck_r(irqAck_r), .vectorLoad_r(vectorLoad_r), .vectorIsBreak_r(vectorIsBreak_r),
    .busy_r(busy_r));
  csfu_stack_model stk (.ref_clk(ref_clk), .sys_rst(sys_rst), .pushValid_r(pushValid_r),
    .pushData_r(pushData_r), .stackWord(stackWord), .pushCnt(pushCnt));

  // free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    chk8({7'h00, got}, {7'h00, exp}, m);
  endtask

  // one op, entered and left at a falling edge; outputs settled on return
  // opValid stays high so ops run back to back; the caller drops it before idling
  task automatic doOp(input csfu_pkg::csfu_opcode_type c, input logic [7:0] a,
                      input logic [7:0] m);
    opValid     = 1'b1;
    opIn.code   = c;
    opIn.accVal = a;
    opIn.memVal = m;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // bounded wait for the vector load pulse; a hang ends the run
  task automatic waitVec();
    for (i = 0; i < 8 && vectorLoad_r !== 1'b1; i++) @(negedge ref_clk);
    if (vectorLoad_r !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: no vector load", $time);
      end_sim();
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    opValid = 1'b0;
    opIn = '0;
    pcIn = 16'h0000;
    branchValid = 1'b0;
    branchIn = '0;
    irqRequest = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk8(statusFlags_r, 8'h04, "reset word");
    chk1(zvnValid_r, 1'b1, "reset zvn");
    sys_rst = 1'b0;
    // every set and clear op except OP_CLRV, mode copy follows
    for (k = 0; k < 8; k++) begin
      doOp(sc[k], 8'h00, 8'h00);
      chk8(statusFlags_r, sw[k], "set/clear");
      chk1(memModeActive_r, sw[k][5], "mem mode");
    end
    $display("test set/clear done");
    // binary arithmetic at the signed and unsigned limits
    doOp(csfu_pkg::OP_ADD, 8'h7f, 8'h01);
    chk8(aluResult_r, 8'h80, "add sum");
    chk1(resultValid_r, 1'b1, "result pulse");
    chk8(statusFlags_r, 8'hc4, "signed overflow");
    doOp(csfu_pkg::OP_CLRV, 8'h00, 8'h00);
    chk8(statusFlags_r, 8'h84, "clear v");
    doOp(csfu_pkg::OP_ADD, 8'hff, 8'h01);
    chk8(statusFlags_r, 8'h07, "carry zero");
    doOp(csfu_pkg::OP_SUB, 8'h80, 8'h01);
    chk8(aluResult_r, 8'h7f, "sub diff");
    chk8(statusFlags_r & 8'hfe, 8'h44, "sub overflow");
    doOp(csfu_pkg::OP_CLRC, 8'h00, 8'h00);
    doOp(csfu_pkg::OP_XFER, 8'h00, 8'h00);
    chk8(statusFlags_r, 8'h46, "xfer zero keeps v");
    doOp(csfu_pkg::OP_BITTEST, 8'h80, 8'h80);
    chk8(statusFlags_r, 8'h84, "bit test");
    $display("test binary done");
    // decimal flag leaves shifts alone, corrects add and subtract
    doOp(csfu_pkg::OP_SETD, 8'h00, 8'h00);
    doOp(csfu_pkg::OP_ASL, 8'h85, 8'h85);
    chk8(aluResult_r, 8'h0a, "shift");
    chk8(statusFlags_r, 8'h0d, "shift flags");
    chk1(zvnValid_r, 1'b1, "shift zvn");
    doOp(csfu_pkg::OP_ADD, 8'h09, 8'h01);
    chk8(aluResult_r, 8'h11, "decimal sum");
    chk8(statusFlags_r & 8'h2d, 8'h0c, "decimal flags");
    chk1(zvnValid_r, 1'b0, "decimal zvn");
    // borrow in and out: 00 - 01 - 1 leaves 98 and a borrow
    doOp(csfu_pkg::OP_SUB, 8'h00, 8'h01);
    chk8(aluResult_r, 8'h98, "decimal diff");
    chk8(statusFlags_r & 8'h2d, 8'h0c, "decimal borrow");
    chk1(zvnValid_r, 1'b0, "decimal sub zvn");
    doOp(csfu_pkg::OP_CLRD, 8'h00, 8'h00);
    doOp(csfu_pkg::OP_CLRV, 8'h00, 8'h00);
    doOp(csfu_pkg::OP_XFER, 8'h00, 8'h80);
    opValid = 1'b0;
    chk8(statusFlags_r, 8'h84, "negative xfer");
    chk1(zvnValid_r, 1'b1, "zvn back");
    $display("test decimal done");
    // branch on each flag, both senses, word is 8'h84; requests back to back
    branchValid = 1'b1;
    for (k = 0; k < 8; k++) begin
      branchIn.flagSel = k[2:1];
      branchIn.wantSet = k[0];
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk1(branchDone_r, 1'b1, "branch done");
      chk1(branchTaken_r, 8'h84 >> bx[k[2:1]] & 1'b1 ? k[0] : !k[0], "taken");
    end
    branchValid = 1'b0;
    $display("test branch done");
    // break is taken with interrupts masked
    pcIn = 16'h1234;
    doOp(csfu_pkg::OP_BREAK, 8'h00, 8'h00);
    opValid = 1'b0;
    chk1(busy_r, 1'b1, "busy in push");
    waitVec();
    chk1(vectorIsBreak_r, 1'b1, "break vector");
    chk1(irqAck_r, 1'b0, "break ack");
    chk1(busy_r, 1'b0, "busy end");
    @(negedge ref_clk);
    chk8(stackWord[23:16], 8'h12, "pch");
    chk8(stackWord[15:8], 8'h34, "pcl");
    chk8(stackWord[7:0], 8'h94, "pushed break");
    chk8(statusFlags_r, 8'h84, "live break bit");
    $display("test break done");
    // unmasked interrupt, then a masked one
    doOp(csfu_pkg::OP_CLRI, 8'h00, 8'h00);
    opValid = 1'b0;
    pcIn = 16'habcd;
    irqRequest = 1'b1;
    @(negedge ref_clk);
    waitVec();
    chk1(irqAck_r, 1'b1, "irq ack");
    chk1(vectorIsBreak_r, 1'b0, "irq vector");
    irqRequest = 1'b0;
    @(negedge ref_clk);
    chk8(stackWord[23:16], 8'hab, "irq pch");
    chk8(stackWord[7:0], 8'h80, "irq status");
    chk8(statusFlags_r, 8'h84, "mask set");
    irqRequest = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk8(pushCnt, 8'h06, "masked irq");
    irqRequest = 1'b0;
    $display("test interrupt done");
    end_sim();
  end
endmodule
